// ===== hw/cfsf_pkg.sv
// Notes on behaviour
// RULE_01 - Eight 24-bit filter setup registers sit at consecutive indices, each resetting to 0x002030, and a channel uses the setup its setup index names.
// RULE_02 - Before a conversion on a channel starts, the settling wait chosen by the three-bit settle field of that channel's setup is observed.
// RULE_03 - Settle code 001 waits 32, 010 waits 64, 110 waits 2048 and 111 waits 4096 master clock cycles, and a 128-cycle option exists.
// RULE_04 - The settling wait is inserted on every change of active channel and never before repeated conversions of the same channel.
// RULE_05 - A repeat field of N converts the channel N+1 times before the sequence moves on.
// RULE_06 - A repeat field of zero converts the channel exactly once.
// RULE_07 - The repeat count is ignored while duty cycling or any calibration mode is enabled.
// RULE_08 - A four-bit filter type field selects sinc4, sinc4 averaging, sinc3, sinc3 with rejection, sinc3 averaging or sinc3 with post-filters, and resets to 0x2.
// RULE_09 - The sinc3 rejection mode adds a notch at 6/5 of the main notch frequency.
// RULE_10 - Rejection mode with a rate divider of 48 gives 50 SPS with 50 Hz and 60 Hz rejected together.
// RULE_11 - The four post-filter options give fixed rates of 26.087, 24, 19.355 and 16.21 SPS.
// RULE_12 - An eleven-bit rate divider field sets the output rate of its setup and resets to 0x30.
// RULE_13 - A rate divider of zero acts as one.
// RULE_14 - Bit 11 of each filter setup register reads as zero and ignores writes.
// RULE_15 - Unlisted settle codes decode consistently, and code 000 adds no settling wait.
package cfsf_pkg;
	localparam int unsigned CFSF_NUM_SETUPS = 8;
	localparam int unsigned CFSF_NUM_CHANS  = 8;
	localparam int unsigned CFSF_REG_W      = 24;
	localparam int unsigned CFSF_ADDR_W     = 10;
	localparam int unsigned CFSF_TIMER_W    = 17;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] CFSF_IDX_CTRL           = 8'h01;
	localparam logic [7:0] CFSF_IDX_CHAN_SETUP     = 8'h02;
	localparam logic [7:0] CFSF_IDX_CHAN_ENABLE    = 8'h03;
	localparam logic [7:0] CFSF_IDX_STATUS         = 8'h04;
	localparam logic [7:0] CFSF_IDX_FILTER_SETUP_0 = 8'h21;
	localparam logic [7:0] CFSF_IDX_FILTER_SETUP_7 = 8'h28;

	localparam logic [23:0] CFSF_FILTER_RESET = 24'h002030;
	localparam logic [23:0] CFSF_FILTER_WMASK = 24'hfff7ff;

	localparam int unsigned CFSF_SETTLE_MSB = 23;
	localparam int unsigned CFSF_SETTLE_LSB = 21;
	localparam int unsigned CFSF_REPEAT_MSB = 20;
	localparam int unsigned CFSF_REPEAT_LSB = 16;
	localparam int unsigned CFSF_FTYPE_MSB  = 15;
	localparam int unsigned CFSF_FTYPE_LSB  = 12;
	localparam int unsigned CFSF_RATE_MSB   = 10;
	localparam int unsigned CFSF_RATE_LSB   = 0;

	localparam int unsigned CFSF_CTRL_RUN  = 0;
	localparam int unsigned CFSF_CTRL_DUTY = 1;
	localparam int unsigned CFSF_CTRL_CAL  = 2;

	// Master clock rate and the system clock it is derived from.
	localparam int unsigned CFSF_CLK_HZ  = 125_000_000;
	localparam int unsigned CFSF_MCLK_HZ = 76_800;
	localparam int unsigned CFSF_MCLK_DIV = CFSF_CLK_HZ / CFSF_MCLK_HZ;

	// Settling waits in master clock cycles.
	localparam logic [16:0] CFSF_SETTLE_000 = 17'h00000;
	localparam logic [16:0] CFSF_SETTLE_001 = 17'h00020;
	localparam logic [16:0] CFSF_SETTLE_010 = 17'h00040;
	localparam logic [16:0] CFSF_SETTLE_011 = 17'h00080;
	localparam logic [16:0] CFSF_SETTLE_100 = 17'h00100;
	localparam logic [16:0] CFSF_SETTLE_101 = 17'h00200;
	localparam logic [16:0] CFSF_SETTLE_110 = 17'h00800;
	localparam logic [16:0] CFSF_SETTLE_111 = 17'h01000;

	// Master clock cycles per output sample for each unit of rate divider.
	localparam int unsigned CFSF_MCLK_PER_RATE = 32;

	// Post-filter output rates in milli-samples per second.
	localparam int unsigned CFSF_PF1_MSPS = 26087;
	localparam int unsigned CFSF_PF2_MSPS = 24000;
	localparam int unsigned CFSF_PF3_MSPS = 19355;
	localparam int unsigned CFSF_PF4_MSPS = 16210;
	localparam int unsigned CFSF_MILLI    = 1000;
	localparam logic [16:0] CFSF_PF1_PERIOD = 17'(CFSF_MCLK_HZ * CFSF_MILLI / CFSF_PF1_MSPS);
	localparam logic [16:0] CFSF_PF2_PERIOD = 17'(CFSF_MCLK_HZ * CFSF_MILLI / CFSF_PF2_MSPS);
	localparam logic [16:0] CFSF_PF3_PERIOD = 17'(CFSF_MCLK_HZ * CFSF_MILLI / CFSF_PF3_MSPS);
	localparam logic [16:0] CFSF_PF4_PERIOD = 17'(CFSF_MCLK_HZ * CFSF_MILLI / CFSF_PF4_MSPS);

	typedef enum logic [3:0] {
		CFSF_F_SINC4     = 4'h0,
		CFSF_F_SINC4_AVG = 4'h1,
		CFSF_F_SINC3     = 4'h2,
		CFSF_F_SINC3_REJ = 4'h3,
		CFSF_F_SINC3_AVG = 4'h4,
		CFSF_F_SINC3_PF1 = 4'h5,
		CFSF_F_SINC3_PF2 = 4'h6,
		CFSF_F_SINC3_PF3 = 4'h7,
		CFSF_F_SINC3_PF4 = 4'h8
	} cfsf_ftype_t;

	typedef enum logic [1:0] {
		CFSF_S_IDLE    = 2'h0,
		CFSF_S_SETTLE  = 2'h1,
		CFSF_S_CONVERT = 2'h3,
		CFSF_S_ADVANCE = 2'h2
	} cfsf_state_t;

	localparam logic [1:0] CFSF_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CFSF_RESP_SLVERR = 2'h2;
endpackage

// ===== hw/cfsf_tick_div.sv
`timescale 1ns/1ps
module cfsf_tick_div
	import cfsf_pkg::*;
#(
	parameter int unsigned DIV = CFSF_MCLK_DIV
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// One-cycle master clock enable.
	output logic      tick
);
	localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

	logic [CNT_W-1:0] count;

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick  <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule

// ===== hw/cfsf_mclk_timer.sv
`timescale 1ns/1ps
module cfsf_mclk_timer
	import cfsf_pkg::*;
#(
	parameter int unsigned WIDTH = CFSF_TIMER_W
) (
	// Clock, reset and master clock enable.
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             tick,
	// Start of a wait and its length in master clock cycles.
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] length,
	// One-cycle pulse when the wait has elapsed.
	output logic                  done
);
	logic [WIDTH-1:0] remain;
	logic             running;

	// A zero length finishes on the cycle after the load.
	always_ff @(posedge clk) begin
		if (rst) begin
			remain  <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end else if (load) begin
			remain  <= length;
			running <= 1'b1;
			done    <= 1'b0;
		end else if (running && remain == '0) begin
			running <= 1'b0;
			done    <= 1'b1;
		end else begin
			done <= 1'b0;
			if (running && tick) begin
				remain <= remain - 1'b1;
			end
		end
	end
endmodule

// ===== hw/cfsf_top.sv
`timescale 1ns/1ps
module cfsf_top
	import cfsf_pkg::*;
#(
	parameter int unsigned MCLK_DIV      = CFSF_MCLK_DIV,
	parameter int unsigned MCLK_PER_RATE = CFSF_MCLK_PER_RATE
) (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   rst,
	// AXI4-Lite write address and data.
	input  wire logic [CFSF_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [CFSF_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Converter sequencing outputs.
	output logic                        conv_start,
	output logic                        conv_done,
	output logic                        settling,
	output logic [2:0]                  active_channel,
	output logic [2:0]                  active_setup,
	output logic [3:0]                  filter_type,
	output logic [10:0]                 output_rate,
	output logic                        sixty_hz_notch
);
	localparam int unsigned TW = CFSF_TIMER_W;

	// Register storage.
	logic [23:0]                 filter_setup [CFSF_NUM_SETUPS];
	logic [2:0]                  ctrl;
	logic [23:0]                 chan_setup;
	logic [7:0]                  chan_enable;

	// Bus slave state.
	logic                        aw_held;
	logic                        w_held;
	logic [CFSF_ADDR_W-1:0]      aw_addr;
	logic [31:0]                 w_data;
	logic [3:0]                  w_strb;
	logic                        do_write;
	logic [7:0]                  wr_idx;
	logic [7:0]                  rd_idx;
	logic                        wr_filter;
	logic [2:0]                  wr_setup;

	// Sequencer state.
	cfsf_state_t                 state;
	logic [2:0]                  cur_ch;
	logic                        last_valid;
	logic [4:0]                  reps_left;
	logic                        timer_load;
	logic [TW-1:0]               timer_len;
	logic                        timer_done;
	logic                        tick;

	// Setup of the channel the sequencer is about to use.
	logic [2:0]                  sel_setup;
	logic [23:0]                 sel_cfg;
	logic [2:0]                  nxt_ch;
	logic                        nxt_change;
	logic [23:0]                 nxt_cfg;

	cfsf_tick_div #(
		.DIV (MCLK_DIV)
	) u_div (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	cfsf_mclk_timer #(
		.WIDTH (TW)
	) u_timer (
		.clk    (clk),
		.rst    (rst),
		.tick   (tick),
		.load   (timer_load),
		.length (timer_len),
		.done   (timer_done)
	);

	function automatic logic [TW-1:0] settle_len(input logic [2:0] code);
		case (code)
			3'h0:    settle_len = CFSF_SETTLE_000; // [RULE_15]
			3'h1:    settle_len = CFSF_SETTLE_001; // [RULE_03]
			3'h2:    settle_len = CFSF_SETTLE_010; // [RULE_03]
			3'h3:    settle_len = CFSF_SETTLE_011; // [RULE_03]
			3'h4:    settle_len = CFSF_SETTLE_100; // [RULE_15]
			3'h5:    settle_len = CFSF_SETTLE_101; // [RULE_15]
			3'h6:    settle_len = CFSF_SETTLE_110; // [RULE_03]
			3'h7:    settle_len = CFSF_SETTLE_111; // [RULE_03]
			default: settle_len = CFSF_SETTLE_000;
		endcase
	endfunction

	// Post-filter modes run at a fixed rate; the rest follow the rate divider.
	function automatic logic [TW-1:0] conv_len(input logic [23:0] cfg);
		logic [10:0] rate;
		rate = cfg[CFSF_RATE_MSB:CFSF_RATE_LSB];
		if (rate == 11'h000) begin
			rate = 11'h001; // [RULE_13]
		end
		case (cfg[CFSF_FTYPE_MSB:CFSF_FTYPE_LSB])
			CFSF_F_SINC3_PF1: conv_len = CFSF_PF1_PERIOD; // [RULE_11]
			CFSF_F_SINC3_PF2: conv_len = CFSF_PF2_PERIOD; // [RULE_11]
			CFSF_F_SINC3_PF3: conv_len = CFSF_PF3_PERIOD; // [RULE_11]
			CFSF_F_SINC3_PF4: conv_len = CFSF_PF4_PERIOD; // [RULE_11]
			default:          conv_len = TW'(rate * MCLK_PER_RATE); // [RULE_12] [RULE_10]
		endcase
	endfunction

	function automatic logic [2:0] next_enabled(input logic [2:0] from, input logic [7:0] en);
		logic [2:0] cand;
		next_enabled = from;
		for (int i = CFSF_NUM_CHANS - 1; i >= 1; i--) begin
			cand = 3'(from + 3'(i));
			if (en[cand]) begin
				next_enabled = cand;
			end
		end
	endfunction

	function automatic logic [2:0] setup_of(input logic [23:0] map, input logic [2:0] ch);
		setup_of = map[ch*3 +: 3];
	endfunction

	// Repeats drop to zero while duty cycling or calibration is on.
	function automatic logic [4:0] repeats(input logic [23:0] cfg, input logic [2:0] c);
		if (c[CFSF_CTRL_DUTY] || c[CFSF_CTRL_CAL]) begin
			repeats = 5'h00; // [RULE_07]
		end else begin
			repeats = cfg[CFSF_REPEAT_MSB:CFSF_REPEAT_LSB]; // [RULE_05] [RULE_06]
		end
	endfunction

	assign sel_setup = setup_of(chan_setup, cur_ch);
	assign sel_cfg   = filter_setup[sel_setup]; // [RULE_01]

	// From idle the first enabled channel is the one after channel 7.
	always_comb begin
		if (state == CFSF_S_IDLE) begin
			nxt_ch = next_enabled(3'h7, chan_enable);
			if (chan_enable[7]) begin
				nxt_ch = (chan_enable[6:0] == 7'h00) ? 3'h7 : nxt_ch;
			end
		end else begin
			nxt_ch = next_enabled(cur_ch, chan_enable);
		end
		nxt_change = !last_valid || nxt_ch != cur_ch; // [RULE_04]
		nxt_cfg    = filter_setup[setup_of(chan_setup, nxt_ch)];
	end

	// Write channel decoding and acceptance.
	assign do_write  = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx    = aw_addr[CFSF_ADDR_W-1:2];
	assign rd_idx    = s_axi_araddr[CFSF_ADDR_W-1:2];
	assign wr_filter = wr_idx >= CFSF_IDX_FILTER_SETUP_0 && wr_idx <= CFSF_IDX_FILTER_SETUP_7;
	assign wr_setup  = 3'(wr_idx - CFSF_IDX_FILTER_SETUP_0);

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (do_write) begin
			aw_held       <= 1'b0;
		end else if (!aw_held && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			w_held       <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (do_write) begin
			w_held       <= 1'b0;
		end else if (!w_held && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CFSF_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (wr_filter || wr_idx == CFSF_IDX_CTRL || wr_idx == CFSF_IDX_CHAN_SETUP
					|| wr_idx == CFSF_IDX_CHAN_ENABLE || wr_idx == CFSF_IDX_STATUS) begin
				s_axi_bresp <= CFSF_RESP_OKAY;
			end else begin
				s_axi_bresp <= CFSF_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Filter setups take byte lanes 0 to 2; bit 11 never stores.
	for (genvar s = 0; s < CFSF_NUM_SETUPS; s++) begin : g_setup
		always_ff @(posedge clk) begin
			if (rst) begin
				filter_setup[s] <= CFSF_FILTER_RESET; // [RULE_01] [RULE_08] [RULE_12]
			end else if (do_write && wr_filter && wr_setup == 3'(s)) begin
				for (int b = 0; b < 3; b++) begin
					if (w_strb[b]) begin
						filter_setup[s][b*8 +: 8] <= w_data[b*8 +: 8] & CFSF_FILTER_WMASK[b*8 +: 8]; // [RULE_14]
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl        <= '0;
			chan_setup  <= '0;
			chan_enable <= '0;
		end else if (do_write) begin
			if (wr_idx == CFSF_IDX_CTRL && w_strb[0]) begin
				ctrl <= w_data[2:0];
			end
			if (wr_idx == CFSF_IDX_CHAN_ENABLE && w_strb[0]) begin
				chan_enable <= w_data[7:0];
			end
			if (wr_idx == CFSF_IDX_CHAN_SETUP) begin
				for (int b = 0; b < 3; b++) begin
					if (w_strb[b]) begin
						chan_setup[b*8 +: 8] <= w_data[b*8 +: 8];
					end
				end
			end
		end
	end

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= CFSF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= CFSF_RESP_OKAY;
			if (rd_idx >= CFSF_IDX_FILTER_SETUP_0 && rd_idx <= CFSF_IDX_FILTER_SETUP_7) begin
				s_axi_rdata <= {8'h00, filter_setup[3'(rd_idx - CFSF_IDX_FILTER_SETUP_0)]};
			end else if (rd_idx == CFSF_IDX_CTRL) begin
				s_axi_rdata <= {29'h0, ctrl};
			end else if (rd_idx == CFSF_IDX_CHAN_SETUP) begin
				s_axi_rdata <= {8'h00, chan_setup};
			end else if (rd_idx == CFSF_IDX_CHAN_ENABLE) begin
				s_axi_rdata <= {24'h0, chan_enable};
			end else if (rd_idx == CFSF_IDX_STATUS) begin
				s_axi_rdata <= {19'h0, reps_left, 1'b0, last_valid, cur_ch, 1'b0, state};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= CFSF_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Sequencer: settle on a channel change, then convert N+1 times.
	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= CFSF_S_IDLE;
			cur_ch     <= '0;
			last_valid <= 1'b0;
			reps_left  <= '0;
			timer_load <= 1'b0;
			timer_len  <= '0;
			conv_start <= 1'b0;
		end else begin
			timer_load <= 1'b0;
			conv_start <= 1'b0;
			case (state)
				CFSF_S_IDLE: begin
					last_valid <= 1'b0;
					if (ctrl[CFSF_CTRL_RUN] && chan_enable != 8'h00) begin
						cur_ch     <= nxt_ch;
						reps_left  <= repeats(nxt_cfg, ctrl);
						timer_load <= 1'b1;
						timer_len  <= settle_len(nxt_cfg[CFSF_SETTLE_MSB:CFSF_SETTLE_LSB]); // [RULE_02]
						state      <= CFSF_S_SETTLE;
					end
				end
				CFSF_S_SETTLE: begin
					if (timer_done) begin
						last_valid <= 1'b1;
						timer_load <= 1'b1;
						timer_len  <= conv_len(sel_cfg);
						conv_start <= 1'b1;
						state      <= CFSF_S_CONVERT;
					end
				end
				CFSF_S_CONVERT: begin
					if (timer_done) begin
						if (reps_left != 5'h00) begin
							reps_left  <= reps_left - 5'h01; // [RULE_05] [RULE_04]
							timer_load <= 1'b1;
							timer_len  <= conv_len(sel_cfg);
							conv_start <= 1'b1;
						end else begin
							state <= CFSF_S_ADVANCE; // [RULE_06]
						end
					end
				end
				CFSF_S_ADVANCE: begin
					if (!ctrl[CFSF_CTRL_RUN] || chan_enable == 8'h00) begin
						state <= CFSF_S_IDLE;
					end else begin
						cur_ch     <= nxt_ch;
						reps_left  <= repeats(nxt_cfg, ctrl);
						timer_load <= 1'b1;
						conv_start <= !nxt_change;
						if (nxt_change) begin
							timer_len <= settle_len(nxt_cfg[CFSF_SETTLE_MSB:CFSF_SETTLE_LSB]); // [RULE_04]
							state     <= CFSF_S_SETTLE;
						end else begin
							timer_len <= conv_len(nxt_cfg);
							state     <= CFSF_S_CONVERT;
						end
					end
				end
				default: state <= CFSF_S_IDLE;
			endcase
		end
	end

	// Registered view of the active setup for the conversion path.
	always_ff @(posedge clk) begin
		if (rst) begin
			conv_done      <= 1'b0;
			settling       <= 1'b0;
			active_channel <= '0;
			active_setup   <= '0;
			filter_type    <= CFSF_FILTER_RESET[CFSF_FTYPE_MSB:CFSF_FTYPE_LSB];
			output_rate    <= CFSF_FILTER_RESET[CFSF_RATE_MSB:CFSF_RATE_LSB];
			sixty_hz_notch <= 1'b0;
		end else begin
			conv_done      <= state == CFSF_S_CONVERT && timer_done;
			settling       <= state == CFSF_S_SETTLE;
			active_channel <= cur_ch;
			active_setup   <= sel_setup;
			filter_type    <= sel_cfg[CFSF_FTYPE_MSB:CFSF_FTYPE_LSB]; // [RULE_08]
			output_rate    <= (sel_cfg[CFSF_RATE_MSB:CFSF_RATE_LSB] == 11'h000) ? 11'h001
				: sel_cfg[CFSF_RATE_MSB:CFSF_RATE_LSB]; // [RULE_13]
			sixty_hz_notch <= sel_cfg[CFSF_FTYPE_MSB:CFSF_FTYPE_LSB] == CFSF_F_SINC3_REJ; // [RULE_09]
		end
	end
endmodule

// ===== verif/cfsf_monitor.sv
`timescale 1ns/1ps
module cfsf_monitor (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rst,
	// Register bus handshakes.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Sequencer.
	input wire logic        conv_start,
	input wire logic        settling,
	input wire logic [2:0]  active_channel,
	input wire logic [3:0]  filter_type,
	input wire logic [10:0] output_rate,
	input wire logic        sixty_hz_notch
);
	logic       seen;
	logic       settled;
	logic       post_start;
	logic [2:0] last_chan;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// The settling flag lags by a cycle, so the cycle after a start is not counted.
	always_ff @(posedge clk) begin
		if (rst) begin
			seen       <= 1'h0;
			settled    <= 1'h0;
			post_start <= 1'h0;
			last_chan  <= 3'h0;
		end else begin
			post_start <= conv_start;
			if (conv_start) begin
				seen      <= 1'h1;
				settled   <= 1'h0;
				last_chan <= active_channel;
			end else if (settling && !post_start) begin
				settled <= 1'h1;
			end
		end
	end

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		(!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
	endsequence
	property p_wr_answer;
		s_wr_taken |=> s_wr_answer;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer out of order");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	property p_r_stand;
		!(s_axi_arvalid && s_axi_arready) |=> $stable(s_axi_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand)
		else $error("read data changed without a read");
	property p_rd_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_rd_done: assert property (p_rd_done)
		else $error("read not closed after acceptance");
	property p_reset_vals;
		$fell(rst) |-> filter_type == 4'h2 && output_rate == 11'h030;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("wrong fields after reset");
	property p_rate_nonzero;
		output_rate != 11'h000;
	endproperty
	a_rate_nonzero: assert property (p_rate_nonzero)
		else $error("rate divider shown as zero");
	property p_notch;
		sixty_hz_notch == (filter_type == 4'h3);
	endproperty
	a_notch: assert property (p_notch)
		else $error("notch flag disagrees with filter type");
	property p_start_pulse;
		conv_start |=> !conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start pulse too long");
	property p_no_resettle;
		conv_start && seen && active_channel == last_chan |-> !settled;
	endproperty
	a_no_resettle: assert property (p_no_resettle)
		else $error("settling before a repeat");
endmodule

bind cfsf_top cfsf_monitor cfsf_monitor_u (
	.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .conv_start(conv_start),
	.settling(settling), .active_channel(active_channel), .filter_type(filter_type),
	.output_rate(output_rate), .sixty_hz_notch(sixty_hz_notch)
);

// ===== verif/cfsf_bench.sv
`timescale 1ns/1ps
module cfsf_bench
	import cfsf_pkg::*;
;
	localparam int DIV = 4;
	typedef struct {
		logic [9:0]  a;
		logic [31:0] d;
		logic [3:0]  s;
		logic [31:0] e;
		logic [1:0]  r;
	} cfsf_row_t;
	cfsf_row_t   rows [5] = '{
		'{10'h084, 32'h00ffffff, 4'hf, 32'h00fff7ff, 2'h0},
		'{10'h0a0, 32'hffabcdef, 4'hf, 32'h00abc5ef, 2'h0},
		'{10'h088, 32'h00ffffff, 4'h1, 32'h000020ff, 2'h0},
		'{10'h090, 32'h12345678, 4'h6, 32'h00345630, 2'h0},
		'{10'h3fc, 32'h00000001, 4'hf, 32'h00000000, CFSF_RESP_SLVERR}};
	logic [31:0] modes [3] = '{32'h1, 32'h3, 32'h5};
	int          reps [3] = '{3, 1, 1};
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [9:0]  awaddr = 10'h000;
	logic [9:0]  araddr = 10'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, conv_start, settling, sixty_hz_notch;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [2:0]  active_channel, active_setup;
	logic [3:0]  filter_type;
	logic [10:0] output_rate;
	logic        conv_done;
	int          err_total = 0, num_checks = 0;

	cfsf_top #(.MCLK_DIV(DIV), .MCLK_PER_RATE(1)) dut_u (
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.conv_start(conv_start), .conv_done(conv_done), .settling(settling),
		.active_channel(active_channel), .active_setup(active_setup),
		.filter_type(filter_type), .output_rate(output_rate), .sixty_hz_notch(sixty_hz_notch));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic stop_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'h1) begin
			err_total++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			check(1'h0, "wait timed out");
			stop_test();
		end
	endtask

	task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (bvalid) break;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		bound(n, 100);
		check(bresp === r, "write response");
	endtask

	task automatic axi_rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (rvalid) break;
			if (arready) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		bound(n, 100);
		check(rdata === e && rresp === r, "read data");
	endtask

	task automatic run_seq(input logic [31:0] ctrl, input int rp);
		int n;
		int k;
		int set_cnt;
		int exp;
		int done_cnt;
		int t0;
		int lo;
		logic c1;
		axi_wr(10'h008, 32'h11, 4'hf, 2'h0);
		axi_wr(10'h088, 32'h223000, 4'hf, 2'h0);
		axi_wr(10'h08c, 32'h0057ff, 4'hf, 2'h0);
		axi_wr(10'h00c, 32'h3, 4'hf, 2'h0);
		axi_wr(10'h004, ctrl, 4'hf, 2'h0);
		k = 0;
		set_cnt = 0;
		done_cnt = 0;
		t0 = 0;
		lo = (CFSF_PF1_PERIOD + 32) * DIV;
		for (n = 0; n < 40000 && k < rp + 2; n++) begin
			@(posedge clk);
			if (settling) set_cnt++;
			if (conv_done) done_cnt++;
			if (conv_start) begin
				c1 = (k == rp);
				exp = (k == 0 || k == rp + 1) ? 32 * DIV : 0;
				check(active_channel === {2'h0, c1}, "channel order");
				check(set_cnt + 4 >= exp && set_cnt <= exp + 8, "settle wait");
				check(active_setup === (c1 ? 3'h2 : 3'h1), "setup index");
				check(filter_type === (c1 ? 4'h5 : 4'h3), "filter type");
				check(sixty_hz_notch === !c1, "notch flag");
				check(output_rate === (c1 ? 11'h7ff : 11'h001), "rate divider");
				check(done_cnt === k, "conversions ended");
				if (k == rp + 1) begin
					check(n - t0 >= lo && n - t0 <= lo + 3 * DIV, "filter period");
				end
				t0 = n;
				set_cnt = 0;
				k++;
			end
		end
		bound(n, 40000);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		check(filter_type === 4'h2 && output_rate === 11'h030, "reset fields");
		for (int i = 0; i < 8; i++) begin
			axi_rd(10'(10'h084 + 4 * i), 32'h00002030, 2'h0);
		end
		foreach (rows[i]) begin
			axi_wr(rows[i].a, rows[i].d, rows[i].s, rows[i].r);
			axi_rd(rows[i].a, rows[i].e, rows[i].r);
		end
		foreach (modes[i]) begin
			rst <= 1'h1;
			repeat (2) @(posedge clk);
			rst <= 1'h0;
			run_seq(modes[i], reps[i]);
		end
		stop_test();
	end
endmodule
